// ---- cpu_regs.sv ----
`timescale 1ns/1ns
`include "cpu_regs_defines.svh"
// Contract
// - sixteen gprs, pc, two supervisor stacks, status
// - stack alias: user, else interrupt/master stack
// - any gpr readable as scaled index
// - data regs: fields, byte, word, long, quad
// - address regs take word and long only
// - pc advances or loads new value
// - five condition flags from previous result
// - user level reaches condition byte only
// - upper status: mask, trace, super, master
// - vector address is base plus displacement
// - source and dest space code registers
// - function codes generated per access space
// - cache control and cache address registers
module cpu_regs
  import cpu_regs_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire gpr_wr_t     gpr_wr_i,
  input  wire field_wr_t   field_wr_i,
  input  wire logic        quad_wr_i,
  input  wire logic [2:0]  quad_hi_sel_i,
  input  wire logic [2:0]  quad_lo_sel_i,
  input  wire logic [63:0] quad_data_i,
  input  wire logic [3:0]  rd_sel_i,
  input  wire logic [3:0]  idx_sel_i,
  input  wire logic        idx_long_i,
  input  wire logic [1:0]  idx_scale_i,
  input  wire logic        pc_inc_i,
  input  wire logic [3:0]  pc_inc_amt_i,
  input  wire logic        pc_load_i,
  input  wire logic [31:0] pc_load_val_i,
  input  wire logic        sw_wr_i,
  input  wire logic [15:0] sw_data_i,
  input  wire logic        flags_upd_i,
  input  wire logic [4:0]  flags_i,
  input  wire logic        ctl_wr_i,
  input  wire ctl_sel_t    ctl_sel_i,
  input  wire logic [31:0] ctl_data_i,
  input  wire logic [7:0]  vec_num_i,
  input  wire logic        acc_prog_i,
  input  wire logic        acc_cpu_i,
  input  wire logic        use_sfc_i,
  input  wire logic        use_dfc_i,
  output logic [31:0]      rd_data_o,
  output logic [31:0]      index_o,
  output logic [31:0]      pc_o,
  output logic [15:0]      status_word_o,
  output logic [31:0]      ctl_rd_o,
  output logic [31:0]      vector_addr_o,
  output logic [2:0]       space_code_o,
  output logic [31:0]      cache_control_o,
  output logic [31:0]      cache_address_o
);
  // ==========================================================
  // storage
  logic [31:0] data_q [8];
  logic [31:0] addr_q [7];
  logic [31:0] user_stack_pointer_q;
  logic [31:0] interrupt_stack_pointer_q;
  logic [31:0] master_stack_pointer_q;
  logic [31:0] pc_q;
  logic [15:0] status_word_reg_q;
  logic [31:0] vector_table_base_q;
  logic [2:0]  source_space_code_q;
  logic [2:0]  dest_space_code_q;
  logic [31:0] cache_control_reg_q;
  logic [31:0] cache_address_reg_q;
  logic        super_w;
  logic        master_w;

  assign super_w  = status_word_reg_q[`SW_SUPER];
  assign master_w = status_word_reg_q[`SW_MASTER];

  // ==========================================================
  // decode helpers
  function automatic logic [31:0] read_gpr(input logic [3:0] sel);
    logic [31:0] v;
    v = `REG32_RESET;
    if (sel == `GPR_STACK_SEL) begin
      if (!super_w) begin
        v = user_stack_pointer_q;
      end else if (master_w) begin
        v = master_stack_pointer_q;
      end else begin
        v = interrupt_stack_pointer_q;
      end
    end else if (sel[3]) begin
      v = addr_q[sel[2:0]];
    end else begin
      v = data_q[sel[2:0]];
    end
    return v;
  endfunction : read_gpr

  function automatic logic [31:0] rotl(input logic [31:0] v,
                                       input logic [4:0]  n);
    logic [63:0] t;
    t = {v, v} << n;
    return t[63:32];
  endfunction : rotl

  // ==========================================================
  // general registers
  logic [31:0] fld_mask_w;
  logic [31:0] gpr_val_w;
  logic [31:0] gpr_cur_w;

  always_comb gpr_cur_w = read_gpr(gpr_wr_i.sel);

  always_comb begin
    fld_mask_w = 32'hffff_ffff;
    if (field_wr_i.width != 5'h00) begin
      fld_mask_w = ~(32'hffff_ffff << field_wr_i.width);
    end
    fld_mask_w = rotl(fld_mask_w, field_wr_i.offset);
  end

  always_comb begin
    gpr_val_w = gpr_cur_w;
    case (gpr_wr_i.size)
      SZ_BYTE: gpr_val_w = {gpr_cur_w[31:8], gpr_wr_i.data[7:0]};
      SZ_WORD: begin
        if (gpr_wr_i.sel[3]) begin
          // word into an address reg is sign extended
          gpr_val_w = {{16{gpr_wr_i.data[15]}}, gpr_wr_i.data[15:0]};
        end else begin
          gpr_val_w = {gpr_cur_w[31:16], gpr_wr_i.data[15:0]};
        end
      end
      SZ_LONG: gpr_val_w = gpr_wr_i.data;
      default: gpr_val_w = gpr_cur_w;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 8; i++) begin
        data_q[i] <= `REG32_RESET;
      end
      for (int i = 0; i < 7; i++) begin
        addr_q[i] <= `REG32_RESET;
      end
      user_stack_pointer_q      <= `REG32_RESET;
      interrupt_stack_pointer_q <= `REG32_RESET;
      master_stack_pointer_q    <= `REG32_RESET;
    end else begin
      // explicit stack moves, supervisor only, lowest priority
      if (ctl_wr_i && super_w) begin
        case (ctl_sel_i)
          CTL_USER_SP:   user_stack_pointer_q      <= ctl_data_i;
          CTL_INT_SP:    interrupt_stack_pointer_q <= ctl_data_i;
          CTL_MASTER_SP: master_stack_pointer_q    <= ctl_data_i;
          default: ;
        endcase
      end
      if (quad_wr_i) begin
        data_q[quad_hi_sel_i] <= quad_data_i[63:32];
        data_q[quad_lo_sel_i] <= quad_data_i[31:0];
      end
      if (field_wr_i.en) begin
        data_q[field_wr_i.sel] <=
          (data_q[field_wr_i.sel] & ~fld_mask_w) |
          (rotl(field_wr_i.data, field_wr_i.offset) & fld_mask_w);
      end
      // byte size to an address reg is dropped
      if (gpr_wr_i.en && !(gpr_wr_i.sel[3] &&
                           gpr_wr_i.size == SZ_BYTE)) begin
        if (gpr_wr_i.sel == `GPR_STACK_SEL) begin
          if (!super_w) begin
            user_stack_pointer_q <= gpr_val_w;
          end else if (master_w) begin
            master_stack_pointer_q <= gpr_val_w;
          end else begin
            interrupt_stack_pointer_q <= gpr_val_w;
          end
        end else if (gpr_wr_i.sel[3]) begin
          addr_q[gpr_wr_i.sel[2:0]] <= gpr_val_w;
        end else begin
          data_q[gpr_wr_i.sel[2:0]] <= gpr_val_w;
        end
      end
    end
  end

  // ==========================================================
  // program counter, load beats increment
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pc_q <= `REG32_RESET;
    end else if (pc_load_i) begin
      pc_q <= pc_load_val_i;
    end else if (pc_inc_i) begin
      pc_q <= pc_q + {28'h0000000, pc_inc_amt_i};
    end
  end

  // ==========================================================
  // status word; an explicit write overrides a flag update
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      status_word_reg_q <= `SW_RESET;
    end else if (sw_wr_i && super_w) begin
      status_word_reg_q <= sw_data_i & `SW_IMPL_MASK;
    end else if (sw_wr_i) begin
      status_word_reg_q <= (status_word_reg_q & ~`SW_COND_MASK) |
                           (sw_data_i & `SW_COND_MASK);
    end else if (flags_upd_i) begin
      status_word_reg_q[`SW_COND_HI:0] <= flags_i;
    end
  end

  // ==========================================================
  // control registers, writes ignored at user level
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      vector_table_base_q <= `REG32_RESET;
      source_space_code_q <= `FC_RESET;
      dest_space_code_q   <= `FC_RESET;
      cache_control_reg_q <= `REG32_RESET;
      cache_address_reg_q <= `REG32_RESET;
    end else if (ctl_wr_i && super_w) begin
      case (ctl_sel_i)
        CTL_VEC_BASE:  vector_table_base_q <= ctl_data_i;
        CTL_SRC_CODE:  source_space_code_q <= ctl_data_i[2:0];
        CTL_DST_CODE:  dest_space_code_q   <= ctl_data_i[2:0];
        CTL_CACHE_CTL: cache_control_reg_q <= ctl_data_i;
        CTL_CACHE_ADR: cache_address_reg_q <= ctl_data_i;
        default:  ;
      endcase
    end
  end

  // ==========================================================
  // registered outputs
  logic [31:0] idx_raw_w;
  logic [31:0] idx_ext_w;
  logic [31:0] ctl_val_w;

  always_comb idx_raw_w = read_gpr(idx_sel_i);
  assign idx_ext_w = idx_long_i ? idx_raw_w :
                     {{16{idx_raw_w[15]}}, idx_raw_w[15:0]};

  always_comb begin
    case (ctl_sel_i)
      CTL_VEC_BASE:  ctl_val_w = vector_table_base_q;
      CTL_SRC_CODE:  ctl_val_w = {29'h0000000, source_space_code_q};
      CTL_DST_CODE:  ctl_val_w = {29'h0000000, dest_space_code_q};
      CTL_CACHE_CTL: ctl_val_w = cache_control_reg_q;
      CTL_CACHE_ADR: ctl_val_w = cache_address_reg_q;
      CTL_USER_SP:   ctl_val_w = user_stack_pointer_q;
      CTL_INT_SP:    ctl_val_w = interrupt_stack_pointer_q;
      CTL_MASTER_SP: ctl_val_w = master_stack_pointer_q;
      default:  ctl_val_w = `REG32_RESET;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_data_o       <= `REG32_RESET;
      index_o         <= `REG32_RESET;
      ctl_rd_o        <= `REG32_RESET;
      vector_addr_o   <= `REG32_RESET;
      space_code_o    <= `FC_RESET;
      pc_o            <= `REG32_RESET;
      status_word_o   <= `SW_RESET;
      cache_control_o <= `REG32_RESET;
      cache_address_o <= `REG32_RESET;
    end else begin
      rd_data_o     <= read_gpr(rd_sel_i);
      index_o       <= idx_ext_w << idx_scale_i;
      // user level reads of control regs return zero
      ctl_rd_o      <= super_w ? ctl_val_w : `REG32_RESET;
      vector_addr_o <= vector_table_base_q +
                       {22'h000000, vec_num_i, 2'h0};
      if (use_sfc_i) begin
        space_code_o <= source_space_code_q;
      end else if (use_dfc_i) begin
        space_code_o <= dest_space_code_q;
      end else if (acc_cpu_i) begin
        space_code_o <= `FC_CPU_SPACE;
      end else begin
        space_code_o <= {super_w, acc_prog_i, ~acc_prog_i};
      end
      pc_o            <= pc_q;
      status_word_o   <= status_word_reg_q;
      cache_control_o <= cache_control_reg_q;
      cache_address_o <= cache_address_reg_q;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence user_stack_read;
    rd_sel_i == `GPR_STACK_SEL && !super_w;
  endsequence
  sequence master_stack_read;
    rd_sel_i == `GPR_STACK_SEL && super_w && master_w;
  endsequence

  AST_USER_STACK: assert property (
    user_stack_read |=> rd_data_o == $past(user_stack_pointer_q))
    else $error("user stack alias wrong");
  AST_MASTER_STACK: assert property (
    master_stack_read |=> rd_data_o == $past(master_stack_pointer_q))
    else $error("master stack alias wrong");
  AST_USER_SW: assert property (
    sw_wr_i && !super_w |=> $stable(status_word_reg_q[15:8]))
    else $error("user changed upper status");
  AST_FLAGS: assert property (
    flags_upd_i && !sw_wr_i |=> status_word_reg_q[4:0] == $past(flags_i)
      ##1 status_word_o[4:0] == $past(flags_i, 2))
    else $error("flags not captured");
  AST_PC_INC: assert property (
    pc_inc_i && !pc_load_i |=>
      pc_q == $past(pc_q) + {28'h0000000, $past(pc_inc_amt_i)})
    else $error("pc increment wrong");
  AST_VECTOR: assert property (
    1'b1 |=> vector_addr_o ==
      $past(vector_table_base_q) + {22'h000000, $past(vec_num_i), 2'h0})
    else $error("vector address wrong");
  AST_CPU_SPACE: assert property (
    acc_cpu_i && !use_sfc_i && !use_dfc_i |=> space_code_o == 3'h7)
    else $error("cpu space code wrong");
  AST_CTL_USER: assert property (
    ctl_wr_i && !super_w |=> $stable(cache_control_reg_q) &&
      $stable(vector_table_base_q))
    else $error("user wrote control reg");
  AST_ADDR_BYTE: assert property (
    gpr_wr_i.en && gpr_wr_i.sel == 4'h9 && gpr_wr_i.size == SZ_BYTE
      |=> $stable(addr_q[1]))
    else $error("byte write hit address reg");
endmodule : cpu_regs

// ---- cpu_regs_defines.svh ----
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH
// status word field positions
`define SW_TRACE_HI    15
`define SW_TRACE_LO    14
`define SW_SUPER       13
`define SW_MASTER      12
`define SW_IPM_HI      10
`define SW_IPM_LO      8
`define SW_COND_HI     4
`define SW_FLAG_X      4
`define SW_FLAG_N      3
`define SW_FLAG_Z      2
`define SW_FLAG_V      1
`define SW_FLAG_C      0
// implemented bits; the rest read as zero
`define SW_IMPL_MASK   16'hf71f
`define SW_COND_MASK   16'h001f
// supervisor, interrupt stack, mask level 7 at reset
`define SW_RESET       16'h2700
`define REG32_RESET    32'h0000_0000
`define FC_RESET       3'h0
`define FC_CPU_SPACE   3'h7
`define GPR_STACK_SEL  4'hf
`define GPR_ADDR_BASE  4'h8
`endif

// ---- cpu_regs_pkg.sv ----
package cpu_regs_pkg;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } op_size_t;

  typedef enum logic [2:0] {
    CTL_VEC_BASE  = 3'h0,
    CTL_SRC_CODE  = 3'h1,
    CTL_DST_CODE  = 3'h2,
    CTL_CACHE_CTL = 3'h3,
    CTL_CACHE_ADR = 3'h4,
    CTL_USER_SP   = 3'h5,
    CTL_INT_SP    = 3'h6,
    CTL_MASTER_SP = 3'h7
  } ctl_sel_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  sel;
    op_size_t    size;
    logic [31:0] data;
  } gpr_wr_t;

  typedef struct packed {
    logic        en;
    logic [2:0]  sel;
    logic [4:0]  offset;
    logic [4:0]  width;
    logic [31:0] data;
  } field_wr_t;
endpackage : cpu_regs_pkg

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import cpu_regs_pkg::*;
  logic        ref_clk_i;
  logic        rst_n_i;
  gpr_wr_t     gpr_wr_i;
  field_wr_t   field_wr_i;
  logic        quad_wr_i;
  logic [2:0]  quad_hi_sel_i;
  logic [2:0]  quad_lo_sel_i;
  logic [63:0] quad_data_i;
  logic [3:0]  rd_sel_i;
  logic [3:0]  idx_sel_i;
  logic        idx_long_i;
  logic [1:0]  idx_scale_i;
  logic        pc_inc_i;
  logic [3:0]  pc_inc_amt_i;
  logic        pc_load_i;
  logic [31:0] pc_load_val_i;
  logic        sw_wr_i;
  logic [15:0] sw_data_i;
  logic        flags_upd_i;
  logic [4:0]  flags_i;
  logic        ctl_wr_i;
  ctl_sel_t    ctl_sel_i;
  logic [31:0] ctl_data_i;
  logic [7:0]  vec_num_i;
  logic        acc_prog_i;
  logic        acc_cpu_i;
  logic        use_sfc_i;
  logic        use_dfc_i;
  logic [31:0] rd_data_o;
  logic [31:0] index_o;
  logic [31:0] pc_o;
  logic [15:0] status_word_o;
  logic [31:0] ctl_rd_o;
  logic [31:0] vector_addr_o;
  logic [2:0]  space_code_o;
  logic [31:0] cache_control_o;
  logic [31:0] cache_address_o;
  int          fails;
  int          total_checks;

  cpu_regs u_dut (
    .ref_clk_i, .rst_n_i, .gpr_wr_i, .field_wr_i, .quad_wr_i,
    .quad_hi_sel_i, .quad_lo_sel_i, .quad_data_i, .rd_sel_i,
    .idx_sel_i, .idx_long_i, .idx_scale_i, .pc_inc_i, .pc_inc_amt_i,
    .pc_load_i, .pc_load_val_i, .sw_wr_i, .sw_data_i, .flags_upd_i,
    .flags_i, .ctl_wr_i, .ctl_sel_i, .ctl_data_i, .vec_num_i,
    .acc_prog_i, .acc_cpu_i, .use_sfc_i, .use_dfc_i, .rd_data_o,
    .index_o, .pc_o, .status_word_o, .ctl_rd_o, .vector_addr_o,
    .space_code_o, .cache_control_o, .cache_address_o
  );

  // ==========================================================
  // helpers
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tk

  task automatic c32(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : c32

  task automatic c16(input logic [15:0] g, input logic [15:0] e);
    c32({16'h0000, g}, {16'h0000, e});
  endtask : c16

  task automatic c3(input logic [2:0] g, input logic [2:0] e);
    c32({29'h0, g}, {29'h0, e});
  endtask : c3

  task automatic gw(input logic [3:0] s, input op_size_t z,
                    input logic [31:0] d);
    @(posedge ref_clk_i);
    gpr_wr_i <= '{en: 1'b1, sel: s, size: z, data: d};
    @(posedge ref_clk_i);
    gpr_wr_i.en <= 1'b0;
  endtask : gw

  task automatic fw(input logic [2:0] s, input logic [4:0] o,
                    input logic [4:0] w, input logic [31:0] d);
    @(posedge ref_clk_i);
    field_wr_i <= '{en: 1'b1, sel: s, offset: o, width: w, data: d};
    @(posedge ref_clk_i);
    field_wr_i.en <= 1'b0;
  endtask : fw

  task automatic cw(input ctl_sel_t s, input logic [31:0] d);
    @(posedge ref_clk_i);
    ctl_wr_i   <= 1'b1;
    ctl_sel_i  <= s;
    ctl_data_i <= d;
    @(posedge ref_clk_i);
    ctl_wr_i <= 1'b0;
  endtask : cw

  task automatic sw(input logic [15:0] d);
    @(posedge ref_clk_i);
    sw_wr_i   <= 1'b1;
    sw_data_i <= d;
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b0;
    tk(2);
  endtask : sw

  task automatic rdc(input logic [3:0] s, input logic [31:0] e);
    @(posedge ref_clk_i);
    rd_sel_i <= s;
    tk(2);
    c32(rd_data_o, e);
  endtask : rdc

  task automatic ctc(input ctl_sel_t s, input logic [31:0] e);
    @(posedge ref_clk_i);
    ctl_sel_i <= s;
    tk(2);
    c32(ctl_rd_o, e);
  endtask : ctc

  task automatic sp(input logic p, input logic c, input logic f,
                    input logic d, input logic [2:0] e);
    @(posedge ref_clk_i);
    acc_prog_i <= p;
    acc_cpu_i  <= c;
    use_sfc_i  <= f;
    use_dfc_i  <= d;
    tk(2);
    c3(space_code_o, e);
  endtask : sp

  task automatic close_out;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // ==========================================================
  // scenarios
  task automatic t_regs;
    gw(4'h3, SZ_LONG, 32'h1234_5678);
    gw(4'h3, SZ_WORD, 32'h0000_abcd);
    gw(4'h3, SZ_BYTE, 32'h0000_0077);
    rdc(4'h3, 32'h1234_ab77);
    gw(4'h9, SZ_WORD, 32'h0000_8001);
    gw(4'h9, SZ_BYTE, 32'h0000_0011);
    rdc(4'h9, 32'hffff_8001);
    gw(4'he, SZ_LONG, 32'hcafe_0001);
    rdc(4'he, 32'hcafe_0001);
    @(posedge ref_clk_i);
    idx_sel_i   <= 4'h9;
    idx_scale_i <= 2'h1;
    tk(2);
    c32(index_o, 32'hffff_0002);
    @(posedge ref_clk_i);
    idx_sel_i   <= 4'h3;
    idx_long_i  <= 1'b1;
    idx_scale_i <= 2'h3;
    tk(2);
    c32(index_o, 32'h91a5_5bb8);
    $display("test regs done");
  endtask : t_regs

  task automatic t_field;
    gw(4'h1, SZ_LONG, 32'h0000_0000);
    fw(3'h1, 5'h04, 5'h08, 32'h0000_00ab);
    fw(3'h1, 5'h10, 5'h04, 32'h0000_0005);
    rdc(4'h1, 32'h0005_0ab0);
    fw(3'h2, 5'h00, 5'h00, 32'hdead_beef);
    rdc(4'h2, 32'hdead_beef);
    @(posedge ref_clk_i);
    quad_wr_i     <= 1'b1;
    quad_hi_sel_i <= 3'h5;
    quad_lo_sel_i <= 3'h6;
    quad_data_i   <= 64'h0123_4567_89ab_cdef;
    @(posedge ref_clk_i);
    quad_wr_i <= 1'b0;
    rdc(4'h5, 32'h0123_4567);
    rdc(4'h6, 32'h89ab_cdef);
    $display("test field done");
  endtask : t_field

  task automatic t_stack_status;
    gw(4'hf, SZ_LONG, 32'h0000_1000);
    ctc(CTL_INT_SP, 32'h0000_1000);
    ctc(CTL_MASTER_SP, 32'h0000_0000);
    sw(16'h3700);
    gw(4'hf, SZ_LONG, 32'h0000_2000);
    rdc(4'hf, 32'h0000_2000);
    ctc(CTL_INT_SP, 32'h0000_1000);
    cw(CTL_USER_SP, 32'h0000_3000);
    ctc(CTL_USER_SP, 32'h0000_3000);
    @(posedge ref_clk_i);
    flags_upd_i <= 1'b1;
    flags_i     <= 5'h0a;
    @(posedge ref_clk_i);
    flags_upd_i <= 1'b0;
    tk(2);
    c16(status_word_o, 16'h370a);
    // explicit write outranks a flag update in the same cycle
    @(posedge ref_clk_i);
    sw_wr_i     <= 1'b1;
    sw_data_i   <= 16'h3703;
    flags_upd_i <= 1'b1;
    flags_i     <= 5'h1f;
    @(posedge ref_clk_i);
    sw_wr_i     <= 1'b0;
    flags_upd_i <= 1'b0;
    tk(2);
    c16(status_word_o, 16'h3703);
    sw(16'hffff);
    c16(status_word_o, 16'hf71f);
    $display("test stack_status done");
  endtask : t_stack_status

  task automatic t_pc_vec_cache;
    @(posedge ref_clk_i);
    pc_inc_i     <= 1'b1;
    pc_inc_amt_i <= 4'h4;
    repeat (2) @(posedge ref_clk_i);
    pc_inc_i <= 1'b0;
    tk(2);
    c32(pc_o, 32'h0000_0008);
    @(posedge ref_clk_i);
    pc_inc_i      <= 1'b1;
    pc_load_i     <= 1'b1;
    pc_load_val_i <= 32'h0000_1000;
    @(posedge ref_clk_i);
    pc_load_i    <= 1'b0;
    pc_inc_amt_i <= 4'h2;
    @(posedge ref_clk_i);
    pc_inc_i <= 1'b0;
    tk(2);
    c32(pc_o, 32'h0000_1002);
    cw(CTL_VEC_BASE, 32'h0001_0000);
    @(posedge ref_clk_i);
    vec_num_i <= 8'hff;
    tk(2);
    c32(vector_addr_o, 32'h0001_03fc);
    @(posedge ref_clk_i);
    vec_num_i <= 8'h40;
    tk(2);
    c32(vector_addr_o, 32'h0001_0100);
    cw(CTL_CACHE_CTL, 32'h0000_0009);
    cw(CTL_CACHE_ADR, 32'h0000_00fc);
    tk(2);
    c32(cache_control_o, 32'h0000_0009);
    c32(cache_address_o, 32'h0000_00fc);
    cw(CTL_SRC_CODE, 32'h0000_0003);
    cw(CTL_DST_CODE, 32'h0000_0002);
    sp(1'b0, 1'b0, 1'b0, 1'b0, 3'h5);
    sp(1'b1, 1'b0, 1'b0, 1'b0, 3'h6);
    sp(1'b0, 1'b1, 1'b0, 1'b0, 3'h7);
    sp(1'b0, 1'b0, 1'b0, 1'b1, 3'h2);
    sp(1'b0, 1'b1, 1'b1, 1'b1, 3'h3);
    $display("test pc_vec_cache done");
  endtask : t_pc_vec_cache

  task automatic t_user;
    sw(16'h0000);
    c16(status_word_o, 16'h0000);
    rdc(4'hf, 32'h0000_3000);
    ctc(CTL_VEC_BASE, 32'h0000_0000);
    sw(16'h2715);
    c16(status_word_o, 16'h0015);
    cw(CTL_VEC_BASE, 32'h0002_0000);
    tk(2);
    c32(vector_addr_o, 32'h0001_0100);
    sp(1'b0, 1'b0, 1'b0, 1'b0, 3'h1);
    sp(1'b1, 1'b0, 1'b0, 1'b0, 3'h2);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    tk(1);
    c16(status_word_o, 16'h2700);
    c32(pc_o, 32'h0000_0000);
    rdc(4'h3, 32'h0000_0000);
    $display("test user done");
  endtask : t_user

  // ==========================================================
  // main sequence
  initial begin
    fails = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    gpr_wr_i = '0;
    field_wr_i = '0;
    quad_wr_i = 1'b0;
    quad_hi_sel_i = 3'h0;
    quad_lo_sel_i = 3'h0;
    quad_data_i = 64'h0;
    rd_sel_i = 4'h0;
    idx_sel_i = 4'h0;
    idx_long_i = 1'b0;
    idx_scale_i = 2'h0;
    pc_inc_i = 1'b0;
    pc_inc_amt_i = 4'h0;
    pc_load_i = 1'b0;
    pc_load_val_i = 32'h0;
    sw_wr_i = 1'b0;
    sw_data_i = 16'h0;
    flags_upd_i = 1'b0;
    flags_i = 5'h0;
    ctl_wr_i = 1'b0;
    ctl_sel_i = CTL_VEC_BASE;
    ctl_data_i = 32'h0;
    vec_num_i = 8'h0;
    acc_prog_i = 1'b0;
    acc_cpu_i = 1'b0;
    use_sfc_i = 1'b0;
    use_dfc_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    tk(1);
    c16(status_word_o, 16'h2700);
    c32(cache_control_o, 32'h0000_0000);
    t_regs();
    t_field();
    t_stack_status();
    t_pc_vec_cache();
    t_user();
    close_out();
  end
endmodule : testbench
